// file: inc/pwr_pkg.sv
// Shared constants and types for the power-save and peripheral clock block.
// Assumes one 50 MHz system clock and an AXI4-Lite master for software access.
package pwr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
	localparam logic [7:0] OFS_PWR_STATUS = 8'h04;
	localparam logic [7:0] OFS_BOOT_CFG = 8'h08;
	localparam logic [7:0] OFS_STOP_IDLE = 8'h0C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OSC_SWITCH_BIT = 0;
	localparam int OSC_SLEEP_SEL_BIT = 4;
	localparam int OSC_NEW_SRC_LSB = 8;
	localparam int OSC_CUR_SRC_LSB = 12;
	localparam int OSC_DIV_LSB = 19;
	localparam int BOOT_DIV_LSB = 12;
	localparam int STAT_STARTING_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [1:0] DIV_RESET = 2'h0;
	localparam logic [2:0] SRC_RESET = 3'h0;
	localparam logic [7:0] XTAL_PLL_SRC_MASK = 8'h0E;
	localparam int STARTUP_CYC_DEF = 1024;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_SLEEP, MODE_START} mode_t;

	typedef struct packed {
		logic pending;
		logic runs_in_sleep;
		logic [2:0] prio;
	} irq_req_t;

endpackage

// file: hw/pb_divider.sv
// Peripheral bus clock divider producing one enable pulse per divided period.
// Assumes the ratio select is a register in the same clock domain.
module pb_divider (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	// Ratio select, 0 to 3 for 1:1 up to 1:8
	input wire logic [1:0] i_div_sel,
	// Divided clock enable
	output logic o_tick
);

	typedef struct packed {
		logic [2:0] cnt;
		logic [1:0] cur;
	} div_state_t;

	div_state_t st_reg;
	div_state_t st_next;
	logic [2:0] limit;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_comb begin
		case (st_reg.cur)
			2'h0: limit = 3'h0;
			2'h1: limit = 3'h1;
			2'h2: limit = 3'h3;
			default: limit = 3'h7;
		endcase
		o_tick = (st_reg.cnt == limit);
		st_next = st_reg;
		if (o_tick) begin
			st_next.cnt = 3'h0;
			st_next.cur = i_div_sel;
		end else begin
			st_next.cnt = st_reg.cnt + 3'h1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st_reg <= '{cnt: 3'h0, cur: pwr_pkg::DIV_RESET};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_div8_spacing;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		(o_tick && st_reg.cur == 2'h3 && i_div_sel == 2'h3) |-> ##1 (!o_tick)[*7] ##1 o_tick;
	endproperty
	a_div8_spacing: assert property (p_div8_spacing) else $error("divide by eight spacing wrong");

	property p_sel_at_boundary;
		@(posedge I_CLK) disable iff (!I_ARST_N)
		!o_tick |=> $stable(st_reg.cur);
	endproperty
	a_sel_at_boundary: assert property (p_sel_at_boundary) else $error("ratio changed mid period");

endmodule

// file: hw/power_save_ctrl.sv
// Sleep and Idle mode control, oscillator start-up delay and peripheral bus clock scaling.
// Assumes an AXI4-Lite master, a CPU that pulses a wait strobe and synchronous inputs.
//
// Notes on behaviour
// - Sleep ends on higher priority sleep interrupt, any reset or watchdog time-out.
// - Low or equal priority sleep interrupt keeps CPU halted, restarts bus clock, enters Idle.
// - Idle halts the CPU while the system clock keeps running.
// - A peripheral whose stop-in-idle bit is set stops in Idle.
// - Wait with the sleep select bit clear enters Idle.
// - Idle ends on an enabled interrupt above the CPU priority.
// - Idle also ends on any reset or a watchdog time-out.
// - Two-bit divisor in the oscillator control register sets ratio 1:1 to 1:8.
// - A divisor change reaches every peripheral on the bus clock.
// - System-clocked blocks ignore the divisor.
// - A peripheral read completes at the next bus clock edge.
// - Switching to a stopped crystal or PLL source inserts start-up delay.
// - Leaving Idle inserts no oscillator start-up delay.
module power_save_ctrl #(
	parameter int NPER = 8,
	parameter int STARTUP_CYC = pwr_pkg::STARTUP_CYC_DEF
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	// AXI4-Lite slave
	input wire logic [pwr_pkg::ADDR_W-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [pwr_pkg::ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	// CPU and wake sources
	input wire logic I_WAIT_EXEC,
	input wire pwr_pkg::irq_req_t I_IRQ,
	input wire logic [2:0] I_CPU_PRIO,
	input wire logic I_DEV_RESET_EVT,
	input wire logic I_WDT_TIMEOUT,
	input wire logic [31:0] I_BOOT_CFG,
	// Peripheral read handshake
	input wire logic I_PERIPH_RD,
	output logic O_PERIPH_RD_DONE,
	// Clock and mode outputs
	output logic O_CPU_HALT,
	output logic O_SYSTEM_CLOCK_RUN,
	output logic O_SYS_DOMAIN_RUN,
	output logic O_PB_CLK_EN,
	output logic [NPER-1:0] O_PERIPH_RUN,
	output logic O_OSC_STARTING,
	output logic [1:0] O_MODE
);

	localparam int CNT_W = $clog2(STARTUP_CYC + 1);
	localparam logic [CNT_W-1:0] START_LOAD = CNT_W'(STARTUP_CYC);
	localparam int OSC_DIV_MSB = pwr_pkg::OSC_DIV_LSB + 1;

	typedef struct packed {
		pwr_pkg::mode_t mode;
		logic [1:0] div;
		logic sleep_sel;
		logic [2:0] new_src;
		logic [2:0] cur_src;
		logic sw_pend;
		logic [CNT_W-1:0] cnt;
		logic [31:0] boot;
		logic boot_done;
		logic [NPER-1:0] stop_in_idle;
		logic aw_hold;
		logic [pwr_pkg::ADDR_W-1:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rd_pend;
	} ctrl_state_t;

	ctrl_state_t st_reg;
	ctrl_state_t st_next;
	logic pb_tick;
	logic irq_high;
	logic irq_sleep;
	logic hard_wake;
	logic [31:0] osc_word;
	logic [31:0] merged;

	// ----------------------------------------------------------------
	// Bus clock divider
	// ----------------------------------------------------------------
	pb_divider u_div (
		.I_CLK(I_CLK),
		.I_ARST_N(I_ARST_N),
		.i_div_sel(st_reg.div),
		.o_tick(pb_tick)
	);

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_xtal(input logic [2:0] src);
		return pwr_pkg::XTAL_PLL_SRC_MASK[src];
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		irq_high = I_IRQ.pending && (I_IRQ.prio > I_CPU_PRIO);
		irq_sleep = I_IRQ.pending && I_IRQ.runs_in_sleep;
		hard_wake = I_DEV_RESET_EVT || I_WDT_TIMEOUT;
		osc_word = '0;
		osc_word[OSC_DIV_MSB:pwr_pkg::OSC_DIV_LSB] = st_reg.div;
		osc_word[pwr_pkg::OSC_CUR_SRC_LSB +: 3] = st_reg.cur_src;
		osc_word[pwr_pkg::OSC_NEW_SRC_LSB +: 3] = st_reg.new_src;
		osc_word[pwr_pkg::OSC_SLEEP_SEL_BIT] = st_reg.sleep_sel;
		osc_word[pwr_pkg::OSC_SWITCH_BIT] = st_reg.sw_pend;
		merged = apply_strb(osc_word, st_reg.w_data, st_reg.w_strb);
		st_next = st_reg;

		// Boot word is caught once, after reset release, with its divisor default.
		if (!st_reg.boot_done) begin
			st_next.boot_done = 1'b1;
			st_next.boot = I_BOOT_CFG;
			st_next.div = I_BOOT_CFG[pwr_pkg::BOOT_DIV_LSB +: 2];
		end

		// Start-up counter shared by wake and source switch.
		if (st_reg.cnt != '0) begin
			st_next.cnt = st_reg.cnt - CNT_W'(1);
			if (st_reg.cnt == CNT_W'(1)) begin
				if (st_reg.sw_pend) begin
					st_next.cur_src = st_reg.new_src;
					st_next.sw_pend = 1'b0;
				end
				if (st_reg.mode == pwr_pkg::MODE_START) begin
					st_next.mode = pwr_pkg::MODE_RUN;
				end
			end
		end

		case (st_reg.mode)
			pwr_pkg::MODE_RUN: begin
				if (I_WAIT_EXEC && st_reg.cnt == '0) begin
					st_next.mode = st_reg.sleep_sel ? pwr_pkg::MODE_SLEEP : pwr_pkg::MODE_IDLE;
				end
			end
			pwr_pkg::MODE_IDLE: begin
				if (irq_high || hard_wake) begin
					st_next.mode = pwr_pkg::MODE_RUN;
				end
			end
			pwr_pkg::MODE_SLEEP: begin
				if (hard_wake || (irq_sleep && irq_high)) begin
					if (is_xtal(st_reg.cur_src)) begin
						st_next.mode = pwr_pkg::MODE_START;
						st_next.cnt = START_LOAD;
					end else begin
						st_next.mode = pwr_pkg::MODE_RUN;
					end
				end else if (irq_sleep) begin
					st_next.mode = pwr_pkg::MODE_IDLE;
				end
			end
			default: begin
			end
		endcase

		// AXI write channel.
		if (I_AWVALID && O_AWREADY) begin
			st_next.aw_hold = 1'b1;
			st_next.aw_addr = I_AWADDR;
		end
		if (I_WVALID && O_WREADY) begin
			st_next.w_hold = 1'b1;
			st_next.w_data = I_WDATA;
			st_next.w_strb = I_WSTRB;
		end
		if (st_reg.bvalid && I_BREADY) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid) begin
			st_next.aw_hold = 1'b0;
			st_next.w_hold = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = pwr_pkg::RESP_OKAY;
			if (st_reg.aw_addr == pwr_pkg::OFS_OSC_CTRL) begin
				st_next.div = merged[OSC_DIV_MSB:pwr_pkg::OSC_DIV_LSB];
				st_next.sleep_sel = merged[pwr_pkg::OSC_SLEEP_SEL_BIT];
				st_next.new_src = merged[pwr_pkg::OSC_NEW_SRC_LSB +: 3];
				if (merged[pwr_pkg::OSC_SWITCH_BIT] && !st_reg.sw_pend && st_reg.cnt == '0) begin
					// delay only for stopped crystal or PLL
					if (is_xtal(st_next.new_src) && st_next.new_src != st_reg.cur_src) begin
						st_next.sw_pend = 1'b1;
						st_next.cnt = START_LOAD;
					end else begin
						st_next.cur_src = st_next.new_src;
					end
				end
			end else if (st_reg.aw_addr == pwr_pkg::OFS_STOP_IDLE) begin
				st_next.stop_in_idle = NPER'(apply_strb(32'(st_reg.stop_in_idle), st_reg.w_data, st_reg.w_strb));
			end else if (st_reg.aw_addr == pwr_pkg::OFS_PWR_STATUS || st_reg.aw_addr == pwr_pkg::OFS_BOOT_CFG) begin
				st_next.bresp = pwr_pkg::RESP_OKAY;
			end else begin
				st_next.bresp = pwr_pkg::RESP_SLVERR;
			end
		end

		// AXI read channel.
		if (st_reg.rvalid && I_RREADY) begin
			st_next.rvalid = 1'b0;
		end
		if (I_ARVALID && O_ARREADY) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = pwr_pkg::RESP_OKAY;
			st_next.rdata = '0;
			if (I_ARADDR == pwr_pkg::OFS_OSC_CTRL) begin
				st_next.rdata = osc_word;
			end else if (I_ARADDR == pwr_pkg::OFS_PWR_STATUS) begin
				st_next.rdata[1:0] = st_reg.mode;
				st_next.rdata[pwr_pkg::STAT_STARTING_BIT] = (st_reg.cnt != '0);
			end else if (I_ARADDR == pwr_pkg::OFS_BOOT_CFG) begin
				st_next.rdata = st_reg.boot;
			end else if (I_ARADDR == pwr_pkg::OFS_STOP_IDLE) begin
				st_next.rdata = 32'(st_reg.stop_in_idle);
			end else begin
				st_next.rresp = pwr_pkg::RESP_SLVERR;
			end
		end

		// read waits for bus clock edge
		if (O_PERIPH_RD_DONE) begin
			st_next.rd_pend = 1'b0;
		end else if (I_PERIPH_RD) begin
			st_next.rd_pend = 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st_reg <= '0;
			st_reg.mode <= pwr_pkg::MODE_RUN;
			st_reg.div <= pwr_pkg::DIV_RESET;
			st_reg.cur_src <= pwr_pkg::SRC_RESET;
			st_reg.new_src <= pwr_pkg::SRC_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign O_AWREADY = !st_reg.aw_hold && !st_reg.bvalid;
	assign O_WREADY = !st_reg.w_hold && !st_reg.bvalid;
	assign O_BVALID = st_reg.bvalid;
	assign O_BRESP = st_reg.bresp;
	assign O_ARREADY = !st_reg.rvalid;
	assign O_RVALID = st_reg.rvalid;
	assign O_RDATA = st_reg.rdata;
	assign O_RRESP = st_reg.rresp;
	assign O_CPU_HALT = (st_reg.mode != pwr_pkg::MODE_RUN);
	assign O_SYSTEM_CLOCK_RUN = (st_reg.mode != pwr_pkg::MODE_SLEEP);
	assign O_SYS_DOMAIN_RUN = O_SYSTEM_CLOCK_RUN;
	assign O_PB_CLK_EN = pb_tick && O_SYSTEM_CLOCK_RUN && (st_reg.mode != pwr_pkg::MODE_START);
	assign O_PERIPH_RD_DONE = st_reg.rd_pend && pb_tick;
	assign O_OSC_STARTING = (st_reg.cnt != '0);
	assign O_MODE = st_reg.mode;

	for (genvar g = 0; g < NPER; g++) begin : g_per
		assign O_PERIPH_RUN[g] = O_PB_CLK_EN && !(st_reg.stop_in_idle[g] && st_reg.mode == pwr_pkg::MODE_IDLE);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	sequence s_in_sleep;
		st_reg.mode == pwr_pkg::MODE_SLEEP;
	endsequence
	sequence s_in_idle;
		st_reg.mode == pwr_pkg::MODE_IDLE;
	endsequence

	property p_sleep_wake;
		s_in_sleep ##0 hard_wake |=> st_reg.mode != pwr_pkg::MODE_SLEEP;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not left on wake event");

	property p_sleep_to_idle;
		s_in_sleep ##0 (irq_sleep && !irq_high && !hard_wake) |=> s_in_idle ##0 O_CPU_HALT;
	endproperty
	a_sleep_to_idle: assert property (p_sleep_to_idle) else $error("low priority wake did not enter idle");

	property p_idle_halt;
		s_in_idle |-> O_CPU_HALT && O_SYSTEM_CLOCK_RUN;
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("idle clock state wrong");

	property p_idle_stop;
		s_in_idle |-> (O_PERIPH_RUN & st_reg.stop_in_idle) == '0;
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("stopped peripheral ran in idle");

	property p_wait_idle;
		(st_reg.mode == pwr_pkg::MODE_RUN && I_WAIT_EXEC && !st_reg.sleep_sel && st_reg.cnt == '0) |=> s_in_idle;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("wait did not enter idle");

	property p_idle_stay;
		s_in_idle ##0 (!irq_high && !hard_wake) |=> s_in_idle;
	endproperty
	a_idle_stay: assert property (p_idle_stay) else $error("idle left without cause");

	property p_idle_exit;
		s_in_idle ##0 (irq_high || hard_wake) |=> st_reg.mode == pwr_pkg::MODE_RUN && !O_OSC_STARTING;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle exit late or delayed");

	property p_read_latency;
		(I_PERIPH_RD && !st_reg.rd_pend) |=> ##[0:7] O_PERIPH_RD_DONE;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("peripheral read too slow");

	property p_sleep_startup;
		s_in_sleep ##0 hard_wake ##0 is_xtal(st_reg.cur_src) |=> st_reg.mode == pwr_pkg::MODE_START && O_OSC_STARTING;
	endproperty
	a_sleep_startup: assert property (p_sleep_startup) else $error("no start-up delay after sleep");

	property p_sys_domain;
		(st_reg.mode != pwr_pkg::MODE_SLEEP) |-> O_SYS_DOMAIN_RUN;
	endproperty
	a_sys_domain: assert property (p_sys_domain) else $error("system domain stopped outside sleep");

endmodule

// file: verif/cpu_read_model.sv
// Behavioural CPU side that issues peripheral reads and times their completion.
// Assumes the read done strobe is settled before each rising clock edge.
module cpu_read_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Command from the bench and answer from the block
	input wire logic i_go,
	input wire logic i_done,
	// Request and measured latency
	output logic o_req,
	output logic [3:0] o_lat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy;

	// The request is a single-cycle pulse so a held level starts no second read until the first read completes.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_req <= 1'b0;
			busy <= 1'b0;
			o_lat <= 4'h0;
		end else begin
			o_req <= i_go && !busy;
			if (i_go && !busy) begin
				busy <= 1'b1;
				o_lat <= 4'h0;
			end else if (busy) begin
				if (i_done) busy <= 1'b0;
				else o_lat <= o_lat + 4'h1;
			end
		end
	end
endmodule

// file: verif/power_save_and_peripheral_bus_clock_scaling_tb_top.sv
// Self-checking bench for the power-save and peripheral clock block.
// Assumes the block is built with a short start-up count of 8 cycles.
module power_save_and_peripheral_bus_clock_scaling_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0, prun;
	logic [31:0] wdata = 0, rdata, d, boot = 32'h0000_2000;
	logic [3:0] wstrb = 0, lat;
	logic awready, wready, bvalid, arready, rvalid, prd, pdone, halt, sysrun, domrun, pben, ostart;
	logic wexec = 0, evt = 0, wdt = 0, go = 0;
	logic [1:0] bresp, rresp, mode, r;
	logic [2:0] cprio = 0;
	logic [4:0] c;
	pwr_pkg::irq_req_t irq = '0;
	int miscompares = 0, checks_done = 0, ticks = 0;
	typedef struct packed {logic [1:0] code; logic [4:0] np;} row_t;
	row_t rows[4] = '{'{2'h0, 5'h10}, '{2'h1, 5'h08}, '{2'h2, 5'h04}, '{2'h3, 5'h02}};

	always #10 clk = ~clk;

	power_save_ctrl #(.NPER(8), .STARTUP_CYC(8)) power_save_ctrl_inst (
		.I_CLK(clk), .I_ARST_N(rst_n),
		.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
		.O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
		.I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_WAIT_EXEC(wexec), .I_IRQ(irq), .I_CPU_PRIO(cprio), .I_DEV_RESET_EVT(evt),
		.I_WDT_TIMEOUT(wdt), .I_BOOT_CFG(boot), .I_PERIPH_RD(prd), .O_PERIPH_RD_DONE(pdone),
		.O_CPU_HALT(halt), .O_SYSTEM_CLOCK_RUN(sysrun), .O_SYS_DOMAIN_RUN(domrun),
		.O_PB_CLK_EN(pben), .O_PERIPH_RUN(prun), .O_OSC_STARTING(ostart), .O_MODE(mode)
	);

	cpu_read_model cpu_read_model_inst (
		.i_clk(clk), .i_arst_n(rst_n), .i_go(go), .i_done(pdone), .o_req(prd), .o_lat(lat)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Readiness is sampled mid-cycle, so the edge that takes an item is known in advance.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ta, tw, b;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ta = 0;
		tw = 0;
		b = 0;
		while (!(ta && tw)) begin
			@(negedge clk);
			ta = ta || awready;
			tw = tw || wready;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		while (!b) begin
			@(negedge clk);
			b = bvalid;
			rs = bresp;
			@(posedge clk);
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic t;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 0;
		while (!t) begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		t = 0;
		while (!t) begin
			@(negedge clk);
			t = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge clk);
		end
		rready <= 1'b0;
	endtask

	task automatic cnt(input int n, output logic [4:0] k);
		k = 0;
		repeat (n) begin
			@(negedge clk);
			k += 5'(pben);
		end
		@(posedge clk);
	endtask

	task automatic wt();
		wexec <= 1'b1;
		@(posedge clk);
		wexec <= 1'b0;
		cyc(2);
	endtask

	task automatic wrap_up();
		$display("counts: %0d checks, %0d wrong", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge clk) begin
		ticks <= ticks + 1;
		if (ticks == 6000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(pwr_pkg::OFS_BOOT_CFG, d, r);
		chk(d, boot);
		rd(pwr_pkg::OFS_OSC_CTRL, d, r);
		chk(d[20:19], 2'h2);
		wr(pwr_pkg::OFS_PWR_STATUS, 32'hFFFF_FFFF, r);
		chk(r, pwr_pkg::RESP_OKAY);
		rd(pwr_pkg::OFS_PWR_STATUS, d, r);
		chk(d[1:0], pwr_pkg::MODE_RUN);
		wr(8'h10, 32'h0000_0001, r);
		chk(r, pwr_pkg::RESP_SLVERR);
		rd(8'h10, d, r);
		chk(r, pwr_pkg::RESP_SLVERR);
		$display("test reset and map done");
		foreach (rows[i]) begin
			wr(pwr_pkg::OFS_OSC_CTRL, 32'(rows[i].code) << 19, r);
			cyc(10);
			cnt(16, c);
			chk(c, rows[i].np);
			chk(domrun, 1'b1);
			@(negedge clk);
			chk(prun, {8{pben}});
			@(posedge clk);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			cyc(12);
			chk(lat >= 1 && lat <= 5'h10 / rows[i].np, 1'b1);
		end
		$display("test divisor table done");
		wr(pwr_pkg::OFS_STOP_IDLE, 32'h0000_0001, r);
		wr(pwr_pkg::OFS_OSC_CTRL, 32'h0, r);
		wt();
		chk(mode, pwr_pkg::MODE_IDLE);
		chk({halt, sysrun}, 2'h3);
		c = 0;
		d = 0;
		repeat (8) begin
			@(negedge clk);
			d[0] = d[0] | prun[0];
			c += 5'(prun[1]);
		end
		@(posedge clk);
		chk({d[0], c}, 6'h08);
		irq <= '{1'b1, 1'b0, 3'h3};
		cprio <= 3'h3;
		cyc(4);
		chk(mode, pwr_pkg::MODE_IDLE);
		irq <= '{1'b1, 1'b0, 3'h4};
		cyc(2);
		chk({mode, ostart}, {pwr_pkg::MODE_RUN, 1'b0});
		irq <= '0;
		for (int k = 0; k < 2; k++) begin
			wt();
			chk(mode, pwr_pkg::MODE_IDLE);
			if (k == 0) wdt <= 1'b1;
			else evt <= 1'b1;
			@(posedge clk);
			wdt <= 1'b0;
			evt <= 1'b0;
			cyc(2);
			chk(mode, pwr_pkg::MODE_RUN);
		end
		$display("test idle done");
		wr(pwr_pkg::OFS_OSC_CTRL, 32'h0000_0010, r);
		wt();
		chk({mode, sysrun}, {pwr_pkg::MODE_SLEEP, 1'b0});
		cnt(8, c);
		chk(c, 5'h0);
		irq <= '{1'b1, 1'b1, 3'h2};
		cyc(2);
		chk({mode, halt}, {pwr_pkg::MODE_IDLE, 1'b1});
		cnt(4, c);
		chk(c, 5'h4);
		irq <= '{1'b1, 1'b1, 3'h5};
		cyc(2);
		chk(mode, pwr_pkg::MODE_RUN);
		for (int k = 0; k < 2; k++) begin
			irq <= '0;
			wt();
			chk(mode, pwr_pkg::MODE_SLEEP);
			if (k == 0) irq <= '{1'b1, 1'b1, 3'h5};
			else evt <= 1'b1;
			@(posedge clk);
			evt <= 1'b0;
			cyc(2);
			chk({mode, halt}, {pwr_pkg::MODE_RUN, 1'b0});
		end
		irq <= '0;
		$display("test sleep done");
		wr(pwr_pkg::OFS_OSC_CTRL, 32'h0000_0111, r);
		cyc(20);
		rd(pwr_pkg::OFS_OSC_CTRL, d, r);
		chk(d[14:12], 3'h1);
		wt();
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		cyc(2);
		chk({mode, ostart}, {pwr_pkg::MODE_START, 1'b1});
		cyc(12);
		chk({mode, ostart}, {pwr_pkg::MODE_RUN, 1'b0});
		$display("test start-up delay done");
		wt();
		chk(mode, pwr_pkg::MODE_SLEEP);
		rst_n <= 1'b0;
		cyc(2);
		chk({mode, halt, sysrun, ostart}, {pwr_pkg::MODE_RUN, 3'h2});
		rst_n <= 1'b1;
		@(posedge clk);
		rd(pwr_pkg::OFS_OSC_CTRL, d, r);
		chk({d[20:19], d[4]}, 3'h4);
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule
